// File: stack_mem_pkg.sv
// Function
// - no stack overflow check, wraps freely
// - stacks in register file or data memory
// - external stack ops always use data space
// - user pointer high ech, low edh
// - system pointer high eeh, low efh
// - space select instructions hold until changed
// - after data select, references use data
// - rom 0000-bfff, ram fd80-ffff decoded
// - ram same range in both spaces
// - vectors live in locations 0000-00ff
// - vector high byte even, low odd
// - push predecrements, pop postincrements pointer
// - register-file stack uses low byte only
// - select bit 1 internal, system resets 1
`default_nettype none
package stack_mem_pkg;
  // system register addresses
  localparam logic [7:0] USER_SP_HIGH_ADDR = 8'hec;
  localparam logic [7:0] USER_SP_LOW_ADDR = 8'hed;
  localparam logic [7:0] SYS_SP_HIGH_ADDR = 8'hee;
  localparam logic [7:0] SYS_SP_LOW_ADDR = 8'hef;
  localparam logic [7:0] CORE_MODE_ADDR = 8'heb;
  // stack select bit positions in the mode register
  localparam int SYS_SEL_BIT = 7;
  localparam int USER_SEL_BIT = 6;
  localparam logic SYS_SEL_RESET = 1'h1;
  localparam logic USER_SEL_RESET = 1'h1;
  localparam logic SPACE_RESET = 1'h0;
  // memory map, largest configuration
  localparam logic [15:0] ROM_LAST = 16'hbfff;
  localparam logic [15:0] RAM_FIRST = 16'hfd80;
  localparam logic [15:0] RAM_LAST = 16'hffff;
  localparam logic [15:0] VECTOR_LAST = 16'h00ff;
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PUSH_DEC = 3'b001,
    ST_PUSH_WR = 3'b010,
    ST_POP_RD = 3'b011,
    ST_POP_INC = 3'b100,
    ST_VEC_HI = 3'b101,
    ST_VEC_LO = 3'b110
  } seq_state_e;
endpackage
`default_nettype wire

// File: mem_region_decode.sv
`timescale 1ns/1ps
`default_nettype none
// address to on-chip region; ram ignores the space flag
module mem_region_decode (
  // address in
  input wire logic [15:0] i_addr,
  // region hits
  output logic o_rom_hit,
  output logic o_ram_hit,
  output logic o_vector_hit
);
  // ram answers in program and data space alike
  assign o_ram_hit = (i_addr >= stack_mem_pkg::RAM_FIRST) &&
                     (i_addr <= stack_mem_pkg::RAM_LAST);
  // rom range starts at zero
  assign o_rom_hit = (i_addr <= stack_mem_pkg::ROM_LAST);
  // vector table area is the bottom of rom
  assign o_vector_hit = (i_addr <= stack_mem_pkg::VECTOR_LAST);
endmodule
`default_nettype wire

// File: stack_pointer_memory_map.sv
`timescale 1ns/1ps
`default_nettype none
module stack_pointer_memory_map (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // system register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // space select instructions
  input wire logic i_set_data_space,
  input wire logic i_select_program_space_instr,
  // stack requests
  input wire logic i_stack_push,
  input wire logic i_stack_pop,
  input wire logic i_stack_user,
  input wire logic i_stack_word,
  input wire logic [15:0] i_push_data,
  output logic [15:0] o_pop_data,
  output logic o_stack_done,
  // vector fetch
  input wire logic i_vec_req,
  input wire logic [6:0] i_vec_num,
  output logic o_pc_load,
  output logic [15:0] o_pc_value,
  // ordinary memory references
  input wire logic i_mem_req,
  input wire logic i_mem_wr,
  input wire logic [15:0] i_mem_addr,
  input wire logic [7:0] i_mem_wdata,
  output logic o_busy,
  // access port, memory answers in the same cycle
  input wire logic [7:0] i_acc_rdata,
  output logic o_acc_valid,
  output logic o_acc_write,
  output logic [15:0] o_acc_addr,
  output logic [7:0] o_acc_wdata,
  output logic o_acc_regfile,
  output logic o_acc_data_space,
  output logic o_acc_rom,
  output logic o_acc_ram,
  output logic o_data_space
);
  // pointer storage, index 0 system, 1 user; no reset, contents undefined
  logic [15:0] sp_reg [2];
  // stack select bits, 1 means register file
  logic [1:0] sel_reg;
  stack_mem_pkg::seq_state_e state_reg, state_next;
  // latched request fields
  logic op_user_reg, op_word_reg, half_reg;
  logic [15:0] op_data_reg, vec_addr_reg;
  // access address candidates
  logic [15:0] next_addr;
  logic next_rom, next_ram, unused_vec_hit;
  logic start_pop, idle_ref;
  // step pointer by one, width follows stack location
  function automatic logic [15:0] sp_step(input logic [15:0] sp, input logic internal,
                                          input logic up);
    logic [15:0] full;
    logic [7:0] low;
    full = up ? sp + 16'h0001 : sp - 16'h0001;
    low = up ? sp[7:0] + 8'h01 : sp[7:0] - 8'h01;
    // no limit check: stack may run down to address zero and wrap
    sp_step = internal ? {sp[15:8], low} : full;
  endfunction
  // address that a stack access uses
  function automatic logic [15:0] sp_addr(input logic [15:0] sp, input logic internal);
    // high byte is reserved for register-file stacks
    sp_addr = internal ? {8'h00, sp[7:0]} : sp;
  endfunction
  // push wins over pop, stack ops win over vectors and plain references
  assign start_pop = (state_reg == stack_mem_pkg::ST_IDLE) && !i_stack_push && i_stack_pop;
  assign idle_ref = (state_reg == stack_mem_pkg::ST_IDLE) && !i_stack_push && !i_stack_pop &&
                    !i_vec_req && i_mem_req;
  // address presented on the next access, for region decode
  always_comb begin
    next_addr = i_mem_addr;
    case (state_reg)
      stack_mem_pkg::ST_PUSH_DEC: begin
        next_addr = sp_addr(sp_step(sp_reg[op_user_reg], sel_reg[op_user_reg], 1'b0),
                            sel_reg[op_user_reg]);
      end
      stack_mem_pkg::ST_POP_INC: begin
        next_addr = sp_addr(sp_step(sp_reg[op_user_reg], sel_reg[op_user_reg], 1'b1),
                            sel_reg[op_user_reg]);
      end
      stack_mem_pkg::ST_VEC_HI: begin
        next_addr = vec_addr_reg | 16'h0001;
      end
      default: begin
        if (start_pop) begin
          next_addr = sp_addr(sp_reg[i_stack_user], sel_reg[i_stack_user]);
        end else if (i_vec_req && !i_stack_push) begin
          next_addr = {8'h00, i_vec_num, 1'b0};
        end
      end
    endcase
  end
  mem_region_decode u_decode (
    .i_addr(next_addr),
    .o_rom_hit(next_rom),
    .o_ram_hit(next_ram),
    .o_vector_hit(unused_vec_hit)
  );
  // space selection holds until the other instruction runs
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_data_space <= stack_mem_pkg::SPACE_RESET;
    end else if (i_set_data_space) begin
      o_data_space <= 1'b1;
    end else if (i_select_program_space_instr) begin
      o_data_space <= 1'b0;
    end
  end
  // stack select bits, written through the mode register address
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sel_reg <= {stack_mem_pkg::USER_SEL_RESET, stack_mem_pkg::SYS_SEL_RESET};
    end else if (i_reg_wr && i_reg_addr == stack_mem_pkg::CORE_MODE_ADDR) begin
      sel_reg <= {i_reg_wdata[stack_mem_pkg::USER_SEL_BIT],
                  i_reg_wdata[stack_mem_pkg::SYS_SEL_BIT]};
    end
  end
  // pointers: sequencer steps win over a same-cycle software write
  always_ff @(posedge i_mclk) begin
    if (state_reg == stack_mem_pkg::ST_PUSH_DEC) begin
      sp_reg[op_user_reg] <= sp_step(sp_reg[op_user_reg], sel_reg[op_user_reg], 1'b0);
    end else if (state_reg == stack_mem_pkg::ST_POP_INC) begin
      sp_reg[op_user_reg] <= sp_step(sp_reg[op_user_reg], sel_reg[op_user_reg], 1'b1);
    end else if (i_reg_wr) begin
      if (i_reg_addr == stack_mem_pkg::USER_SP_HIGH_ADDR) begin
        sp_reg[1][15:8] <= i_reg_wdata;
      end else if (i_reg_addr == stack_mem_pkg::USER_SP_LOW_ADDR) begin
        sp_reg[1][7:0] <= i_reg_wdata;
      end else if (i_reg_addr == stack_mem_pkg::SYS_SP_HIGH_ADDR) begin
        sp_reg[0][15:8] <= i_reg_wdata;
      end else if (i_reg_addr == stack_mem_pkg::SYS_SP_LOW_ADDR) begin
        sp_reg[0][7:0] <= i_reg_wdata;
      end
    end
  end
  // register read port, unmapped addresses read zero
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      if (i_reg_addr == stack_mem_pkg::USER_SP_HIGH_ADDR) begin
        o_reg_rdata <= sp_reg[1][15:8];
      end else if (i_reg_addr == stack_mem_pkg::USER_SP_LOW_ADDR) begin
        o_reg_rdata <= sp_reg[1][7:0];
      end else if (i_reg_addr == stack_mem_pkg::SYS_SP_HIGH_ADDR) begin
        o_reg_rdata <= sp_reg[0][15:8];
      end else if (i_reg_addr == stack_mem_pkg::SYS_SP_LOW_ADDR) begin
        o_reg_rdata <= sp_reg[0][7:0];
      end else if (i_reg_addr == stack_mem_pkg::CORE_MODE_ADDR) begin
        o_reg_rdata <= {sel_reg[0], sel_reg[1], 6'h00};
      end else begin
        o_reg_rdata <= 8'h00;
      end
    end
  end
  // sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      stack_mem_pkg::ST_IDLE: begin
        if (i_stack_push) begin
          state_next = stack_mem_pkg::ST_PUSH_DEC;
        end else if (i_stack_pop) begin
          state_next = stack_mem_pkg::ST_POP_RD;
        end else if (i_vec_req) begin
          state_next = stack_mem_pkg::ST_VEC_HI;
        end
      end
      stack_mem_pkg::ST_PUSH_DEC: state_next = stack_mem_pkg::ST_PUSH_WR;
      stack_mem_pkg::ST_PUSH_WR: begin
        state_next = (op_word_reg && !half_reg) ? stack_mem_pkg::ST_PUSH_DEC
                                                : stack_mem_pkg::ST_IDLE;
      end
      stack_mem_pkg::ST_POP_RD: state_next = stack_mem_pkg::ST_POP_INC;
      stack_mem_pkg::ST_POP_INC: begin
        state_next = (op_word_reg && !half_reg) ? stack_mem_pkg::ST_POP_RD
                                                : stack_mem_pkg::ST_IDLE;
      end
      stack_mem_pkg::ST_VEC_HI: state_next = stack_mem_pkg::ST_VEC_LO;
      default: state_next = stack_mem_pkg::ST_IDLE;
    endcase
  end
  // state register
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_reg <= stack_mem_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end
  // request latch and word half tracking
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      op_user_reg <= 1'b0;
      op_word_reg <= 1'b0;
      half_reg <= 1'b0;
      op_data_reg <= 16'h0000;
      vec_addr_reg <= 16'h0000;
    end else if (state_reg == stack_mem_pkg::ST_IDLE) begin
      op_user_reg <= i_stack_user;
      op_word_reg <= i_stack_word;
      half_reg <= 1'b0;
      op_data_reg <= i_push_data;
      vec_addr_reg <= {8'h00, i_vec_num, 1'b0};
    end else if (state_reg == stack_mem_pkg::ST_PUSH_WR ||
                 state_reg == stack_mem_pkg::ST_POP_INC) begin
      half_reg <= 1'b1;
    end
  end
  // access port drive, one byte per access
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_acc_valid <= 1'b0;
      o_acc_write <= 1'b0;
      o_acc_addr <= 16'h0000;
      o_acc_wdata <= 8'h00;
      o_acc_regfile <= 1'b0;
      o_acc_data_space <= 1'b0;
      o_acc_rom <= 1'b0;
      o_acc_ram <= 1'b0;
    end else begin
      o_acc_addr <= next_addr;
      o_acc_rom <= next_rom;
      o_acc_ram <= next_ram;
      o_acc_valid <= 1'b0;
      o_acc_write <= 1'b0;
      if (state_reg == stack_mem_pkg::ST_PUSH_DEC) begin
        // low byte first so the high byte ends at the lower address
        o_acc_valid <= 1'b1;
        o_acc_write <= 1'b1;
        o_acc_wdata <= (!op_word_reg || !half_reg) ? op_data_reg[7:0] : op_data_reg[15:8];
        o_acc_regfile <= sel_reg[op_user_reg];
        o_acc_data_space <= 1'b1;
      end else if (state_reg == stack_mem_pkg::ST_POP_INC && op_word_reg && !half_reg) begin
        o_acc_valid <= 1'b1;
        o_acc_regfile <= sel_reg[op_user_reg];
        o_acc_data_space <= 1'b1;
      end else if (state_reg == stack_mem_pkg::ST_VEC_HI) begin
        o_acc_valid <= 1'b1;
        o_acc_regfile <= 1'b0;
        o_acc_data_space <= 1'b0;
      end else if (start_pop) begin
        o_acc_valid <= 1'b1;
        o_acc_regfile <= sel_reg[i_stack_user];
        o_acc_data_space <= 1'b1;
      end else if (state_reg == stack_mem_pkg::ST_IDLE && !i_stack_push && i_vec_req) begin
        // vectors are fetched from program space
        o_acc_valid <= 1'b1;
        o_acc_regfile <= 1'b0;
        o_acc_data_space <= 1'b0;
      end else if (idle_ref) begin
        o_acc_valid <= 1'b1;
        o_acc_write <= i_mem_wr;
        o_acc_wdata <= i_mem_wdata;
        o_acc_regfile <= 1'b0;
        // follows the space selected by the last instruction
        o_acc_data_space <= o_data_space;
      end
    end
  end
  // pop data, done pulse, program counter load
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_pop_data <= 16'h0000;
      o_stack_done <= 1'b0;
      o_pc_load <= 1'b0;
      o_pc_value <= 16'h0000;
      o_busy <= 1'b0;
    end else begin
      o_stack_done <= (state_reg == stack_mem_pkg::ST_PUSH_WR ||
                       state_reg == stack_mem_pkg::ST_POP_INC) &&
                      (state_next == stack_mem_pkg::ST_IDLE);
      o_pc_load <= (state_reg == stack_mem_pkg::ST_VEC_LO);
      o_busy <= (state_next != stack_mem_pkg::ST_IDLE);
      if (state_reg == stack_mem_pkg::ST_POP_RD) begin
        // read before the pointer moves; first byte is the high byte
        o_pop_data <= op_word_reg ? {o_pop_data[7:0], i_acc_rdata}
                                  : {8'h00, i_acc_rdata};
      end
      if (state_reg == stack_mem_pkg::ST_VEC_HI) begin
        o_pc_value[15:8] <= i_acc_rdata;
      end else if (state_reg == stack_mem_pkg::ST_VEC_LO) begin
        o_pc_value[7:0] <= i_acc_rdata;
      end
    end
  end
endmodule
`default_nettype wire

// File: stack_pointer_memory_map_properties.sv
`timescale 1ns/1ps
`default_nettype none
// port-level watch on stack, vector, space and decode behaviour
module stack_pointer_memory_map_properties (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // requests
  input wire logic i_set_data_space,
  input wire logic i_select_program_space_instr,
  input wire logic i_stack_push,
  input wire logic i_stack_pop,
  input wire logic i_stack_word,
  input wire logic i_vec_req,
  input wire logic [6:0] i_vec_num,
  input wire logic i_mem_req,
  input wire logic [7:0] i_acc_rdata,
  // answers
  input wire logic o_busy,
  input wire logic o_stack_done,
  input wire logic o_pc_load,
  input wire logic [15:0] o_pc_value,
  input wire logic o_acc_valid,
  input wire logic o_acc_write,
  input wire logic [15:0] o_acc_addr,
  input wire logic o_acc_regfile,
  input wire logic o_acc_data_space,
  input wire logic o_acc_rom,
  input wire logic o_acc_ram,
  input wire logic o_data_space
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // a start with no stack request competing
  logic idle_go;
  assign idle_go = !o_busy && !i_stack_push && !i_stack_pop;
  a_space_to_data: assert property (i_set_data_space |=> o_data_space)
    else $error("data space not selected");
  a_space_to_prog: assert property (
    i_select_program_space_instr && !i_set_data_space |=> !o_data_space)
    else $error("program space not selected");
  a_space_holds: assert property (
    !i_set_data_space && !i_select_program_space_instr |=> $stable(o_data_space))
    else $error("space changed without instruction");
  a_ram_decode: assert property (
    o_acc_valid && !o_acc_regfile |-> o_acc_ram == (o_acc_addr >= 16'hfd80))
    else $error("ram decode wrong");
  a_rom_decode: assert property (
    o_acc_valid && !o_acc_regfile |-> o_acc_rom == (o_acc_addr <= 16'hbfff))
    else $error("rom decode wrong");
  a_pop_ext_data: assert property (
    i_stack_pop && !i_stack_push && !o_busy
    |=> o_acc_valid && !o_acc_write && (o_acc_regfile || o_acc_data_space))
    else $error("pop access not in data space");
  a_push_byte_seq: assert property (
    i_stack_push && !o_busy && !i_stack_word
    |-> ##1 !o_stack_done ##1 (o_acc_valid && o_acc_write) ##1 o_stack_done)
    else $error("byte push sequence wrong");
  a_pop_word_done: assert property (
    i_stack_pop && !i_stack_push && !o_busy && i_stack_word |-> ##5 o_stack_done)
    else $error("word pop not done in time");
  a_vec_fetch: assert property (
    i_vec_req && idle_go
    |=> (o_acc_valid && !o_acc_data_space
         && o_acc_addr == {8'h00, $past(i_vec_num), 1'h0})
    ##1 (o_acc_valid && o_acc_addr[0])
    ##1 (o_pc_load && o_pc_value == {$past(i_acc_rdata, 2), $past(i_acc_rdata)}))
    else $error("vector fetch wrong");
  a_ref_space: assert property (
    i_mem_req && idle_go && !i_vec_req && !i_set_data_space
    && !i_select_program_space_instr |=> o_acc_valid && o_acc_data_space == o_data_space)
    else $error("reference space wrong");
endmodule
bind stack_pointer_memory_map stack_pointer_memory_map_properties i_props (
  .i_mclk, .i_rst, .i_set_data_space, .i_select_program_space_instr,
  .i_stack_push, .i_stack_pop, .i_stack_word, .i_vec_req, .i_vec_num,
  .i_mem_req, .i_acc_rdata, .o_busy, .o_stack_done, .o_pc_load, .o_pc_value,
  .o_acc_valid, .o_acc_write, .o_acc_addr, .o_acc_regfile, .o_acc_data_space,
  .o_acc_rom, .o_acc_ram, .o_data_space);
`default_nettype wire

// File: tb_stack_pointer_memory_map.sv
`timescale 1ns/1ps
`default_nettype none
module tb_stack_pointer_memory_map;
  // stimulus, all valued at time zero
  logic i_mclk = 1'h0, i_rst = 1'h1, i_reg_wr = 1'h0, i_reg_rd = 1'h0;
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, i_mem_wdata = 8'h00;
  logic i_set_data_space = 1'h0, i_select_program_space_instr = 1'h0;
  logic i_stack_push = 1'h0, i_stack_pop = 1'h0, i_stack_user = 1'h0;
  logic i_stack_word = 1'h0, i_vec_req = 1'h0, i_mem_req = 1'h0, i_mem_wr = 1'h0;
  logic [15:0] i_push_data = 16'h0000, i_mem_addr = 16'h0000;
  logic [6:0] i_vec_num = 7'h00;
  // outputs
  logic [7:0] o_reg_rdata, o_acc_wdata;
  logic [15:0] o_pop_data, o_pc_value, o_acc_addr;
  logic o_stack_done, o_pc_load, o_busy, o_acc_valid, o_acc_write;
  logic o_acc_regfile, o_acc_data_space, o_acc_rom, o_acc_ram, o_data_space;
  // memory answers same cycle; content derived from address
  wire logic [7:0] i_acc_rdata = o_acc_addr[7:0] ^ 8'h3c;
  // last access seen, for judging writes and decode
  logic [15:0] w_addr;
  logic [7:0] w_data;
  logic w_wr, w_rf, w_ds, w_rom, w_ram;
  int errors = 0, total_checks = 0;
  stack_pointer_memory_map i_dut (.i_mclk, .i_rst, .i_reg_addr, .i_reg_wr, .i_reg_rd,
    .i_reg_wdata, .o_reg_rdata, .i_set_data_space, .i_select_program_space_instr,
    .i_stack_push, .i_stack_pop, .i_stack_user, .i_stack_word, .i_push_data,
    .o_pop_data, .o_stack_done, .i_vec_req, .i_vec_num, .o_pc_load, .o_pc_value,
    .i_mem_req, .i_mem_wr, .i_mem_addr, .i_mem_wdata, .o_busy, .i_acc_rdata,
    .o_acc_valid, .o_acc_write, .o_acc_addr, .o_acc_wdata, .o_acc_regfile,
    .o_acc_data_space, .o_acc_rom, .o_acc_ram, .o_data_space);
  // free-running clock, 20 ns
  initial begin
    forever #10 i_mclk = ~i_mclk;
  end
  // access monitor
  always @(posedge i_mclk) begin
    if (o_acc_valid === 1'h1) begin
      {w_addr, w_data, w_wr, w_rf, w_ds, w_rom, w_ram} <= {o_acc_addr, o_acc_wdata, o_acc_write,
        o_acc_regfile, o_acc_data_space, o_acc_rom, o_acc_ram};
    end
  end
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    {i_reg_addr, i_reg_wdata, i_reg_wr} <= {a, d, 1'h1};
    @(posedge i_mclk);
    i_reg_wr <= 1'h0;
  endtask
  // read data is registered, looked at the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_mclk);
    {i_reg_addr, i_reg_rd} <= {a, 1'h1};
    @(posedge i_mclk);
    i_reg_rd <= 1'h0;
    @(posedge i_mclk);
    #1 check(o_reg_rdata, exp);
  endtask
  // bounded wait for a stack or vector completion pulse
  task automatic wait_done();
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge i_mclk);
      #1;
      if ((o_stack_done | o_pc_load) === 1'h1) break;
    end
    if (n == 20) begin
      errors++;
      summarize();
    end
  endtask
  task automatic stk(input logic push, input logic user, input logic word,
                     input logic [15:0] d);
    @(posedge i_mclk);
    {i_stack_push, i_stack_pop, i_stack_user, i_stack_word, i_push_data} <=
      {push, !push, user, word, d};
    @(posedge i_mclk);
    {i_stack_push, i_stack_pop} <= 2'h0;
    #1 check({15'h0000, o_busy}, 16'h0001);
    wait_done();
  endtask
  task automatic space(input logic data);
    @(posedge i_mclk);
    {i_set_data_space, i_select_program_space_instr} <= {data, !data};
    @(posedge i_mclk);
    {i_set_data_space, i_select_program_space_instr} <= 2'h0;
  endtask
  task automatic t_regs();
    rd(8'heb, 8'hc0);
    rd(8'he0, 8'h00);
    for (int i = 0; i < 4; i++) wr(8'hec + 8'(i), 8'h11 * 8'(i + 1));
    for (int i = 0; i < 4; i++) rd(8'hec + 8'(i), 8'h11 * 8'(i + 1));
    $display("t_regs done");
  endtask
  // system stack in the register file: predecrement, wrap in low byte
  task automatic t_internal();
    wr(8'hef, 8'hdc);
    stk(1'h1, 1'h0, 1'h0, 16'h005a);
    check(w_addr, 16'h00db);
    check({7'h00, w_rf, w_data}, {7'h00, 1'h1, 8'h5a});
    rd(8'hef, 8'hdb);
    stk(1'h0, 1'h0, 1'h0, 16'h0000);
    check(o_pop_data, {8'h00, 8'hdb ^ 8'h3c});
    rd(8'hef, 8'hdc);
    wr(8'hee, 8'h12);
    wr(8'hef, 8'h00);
    stk(1'h1, 1'h0, 1'h0, 16'h0033);
    rd(8'hef, 8'hff);
    rd(8'hee, 8'h12);
    $display("t_internal done");
  endtask
  // user stack in memory while program space is selected
  task automatic t_external();
    wr(8'heb, 8'h80);
    space(1'h0);
    wr(8'hec, 8'h00);
    wr(8'hed, 8'h00);
    stk(1'h1, 1'h1, 1'h0, 16'h00a5);
    check({12'h000, w_wr, w_ds, w_rf, w_ram}, {12'h000, 4'hd});
    check(w_addr, 16'hffff);
    stk(1'h0, 1'h1, 1'h1, 16'h0000);
    check(o_pop_data, 16'hc33c);
    rd(8'hed, 8'h01);
    wr(8'hec, 8'h10);
    wr(8'hed, 8'h00);
    stk(1'h1, 1'h1, 1'h1, 16'hbeef);
    check(w_addr, 16'h0ffe);
    check({8'h00, w_data}, 16'h00be);
    rd(8'hec, 8'h0f);
    $display("t_external done");
  endtask
  // both spaces, decode boundaries on plain references
  task automatic t_space();
    logic [15:0] a[6] = '{16'h0000, 16'hbfff, 16'hc000, 16'hfd7f, 16'hfd80, 16'hffff};
    for (int s = 0; s < 2; s++) begin
      space(1'(s));
      for (int k = 0; k < 6; k++) begin
        @(posedge i_mclk);
        {i_mem_req, i_mem_wr, i_mem_addr, i_mem_wdata} <= {1'h1, 1'(k), a[k], 8'h40 + 8'(k)};
        @(posedge i_mclk);
        i_mem_req <= 1'h0;
        @(posedge i_mclk);
        #1 check({13'h0, w_ds, w_rom, w_ram},
                 {13'h0, 1'(s), a[k] <= 16'hbfff, a[k] >= 16'hfd80});
        check({7'h00, w_wr, w_data}, {7'h00, 1'(k), 8'h40 + 8'(k)});
      end
    end
    $display("t_space done");
  endtask
  task automatic t_vector();
    logic [6:0] v[4] = '{7'h00, 7'h01, 7'h05, 7'h7f};
    for (int k = 0; k < 4; k++) begin
      @(posedge i_mclk);
      {i_vec_req, i_vec_num} <= {1'h1, v[k]};
      @(posedge i_mclk);
      i_vec_req <= 1'h0;
      wait_done();
      check(o_pc_value, {{v[k], 1'h0} ^ 8'h3c, {v[k], 1'h1} ^ 8'h3c});
    end
    $display("t_vector done");
  endtask
  initial begin
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'h0;
    t_regs();
    t_internal();
    t_external();
    t_space();
    t_vector();
    summarize();
  end
endmodule
`default_nettype wire
